// >>> verilog/csw_map.svh
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH

// Register offsets
`define CSW_OFF_DATA     8'h0c
`define CSW_OFF_CMP      8'h10
`define CSW_OFF_CTL      8'h14
`define CSW_OFF_ROM      8'h18
`define CSW_OFF_BUSID    8'h1c
`define CSW_OFF_STATUS   8'h30
`define CSW_OFF_ENABLE   8'h34
`define CSW_OFF_CLEAR    8'h38
`define CSW_OFF_OLD      8'h3c

// Control fields
`define CSW_DONE_BIT     31
`define CSW_SEL_MSB      1
`define CSW_SEL_LSB      0

// Header fields
`define CSW_INFO_MSB     31
`define CSW_INFO_LSB     24
`define CSW_SPAN_MSB     23
`define CSW_SPAN_LSB     16
`define CSW_CHK_MSB      15
`define CSW_CHK_LSB      0

// Event bits
`define CSW_EV_DONE      0
`define CSW_EV_MATCH     1
`define CSW_EV_MISS      2
`define CSW_EV_REFUSED   3
`define CSW_EV_W         4

// Reset and constant values
`define CSW_ZERO32       32'h0000_0000
`define CSW_ROM_RESET    32'h0000_0000
`define CSW_BUS_ID       32'h3133_3934
`define CSW_RES_RESET    32'hffff_ffff
`define CSW_SEL_RESET    2'h0
`define CSW_DONE_RESET   1'b1
`define CSW_EV_ZERO      4'h0

`endif

// >>> verilog/csw_pkg.sv
package csw_pkg;

  typedef enum logic [1:0] {
    csw_idle   = 2'b00,
    csw_fetch  = 2'b01,
    csw_update = 2'b10
  } csw_state_e;

  typedef enum logic [1:0] {
    csw_res_manager_id = 2'b00,
    csw_res_bandwidth  = 2'b01,
    csw_res_chan_hi    = 2'b10,
    csw_res_chan_lo    = 2'b11
  } csw_res_e;

endpackage

// >>> verilog/csw_regs.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csw_map.svh"

module csw_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic [ADDR_W-1:0] addr,        // Byte address
  input  wire logic              clock,       // 40 MHz clock
  input  wire logic              rst_n,       // Synchronous reset
  input  wire logic [31:0]       wr_data,     // Write data
  input  wire logic              wr_en,       // Write strobe
  input  wire logic              rd_en,       // Read strobe
  output logic      [31:0]       rd_data,     // Read data, next cycle
  output logic                   irq,         // Level interrupt
  output logic      [31:0]       rom_header,  // ROM quadlet 0 image
  output logic      [31:0]       bus_ident,   // Bus info quadlet 0
  output logic                   swap_busy    // Compare-swap running
);

  localparam int NUM_RES = 4;  // One slot per resource select code

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // One offset compare, shared by the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a == ADDR_W'(off));
  endfunction

  logic wr_data_reg;
  logic wr_cmp_reg;
  logic wr_ctl_reg;
  logic wr_rom_reg;
  logic wr_enable_reg;
  logic wr_clear_reg;
  logic wr_operand;

  assign wr_data_reg   = wr_en && hit(addr, `CSW_OFF_DATA);
  assign wr_cmp_reg    = wr_en && hit(addr, `CSW_OFF_CMP);
  assign wr_ctl_reg    = wr_en && hit(addr, `CSW_OFF_CTL);
  assign wr_rom_reg    = wr_en && hit(addr, `CSW_OFF_ROM);
  assign wr_enable_reg = wr_en && hit(addr, `CSW_OFF_ENABLE);
  assign wr_clear_reg  = wr_en && hit(addr, `CSW_OFF_CLEAR);
  assign wr_operand    = wr_cmp_reg || wr_data_reg || wr_ctl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Compare-swap engine

  csw_pkg::csw_state_e state_ff;
  csw_pkg::csw_state_e nxt_state;
  logic [1:0]          op_sel_ff;
  logic [1:0]          nxt_op_sel;
  logic [31:0]         old_ff;
  logic [31:0]         nxt_old;
  logic [31:0]         res_ff     [NUM_RES];
  logic [31:0]         nxt_res    [NUM_RES];
  logic [31:0]         cmp_ff;
  logic [31:0]         data_ff;
  logic                ev_done;
  logic                ev_match;
  logic                ev_miss;

  always_comb begin
    nxt_state  = state_ff;
    nxt_op_sel = op_sel_ff;
    nxt_old    = old_ff;
    ev_done    = 1'b0;
    ev_match   = 1'b0;
    ev_miss    = 1'b0;
    for (int i = 0; i < NUM_RES; i++) begin
      nxt_res[i] = res_ff[i];
    end
    case (state_ff)
      csw_pkg::csw_idle: begin
        if (wr_ctl_reg) begin
          // Resource choice is latched so later writes cannot retarget
          nxt_op_sel = wr_data[`CSW_SEL_MSB:`CSW_SEL_LSB];
          nxt_state  = csw_pkg::csw_fetch;
        end
      end
      csw_pkg::csw_fetch: begin
        // Snapshot once so the compare sees a single value
        nxt_old   = res_ff[op_sel_ff];
        nxt_state = csw_pkg::csw_update;
      end
      csw_pkg::csw_update: begin
        if (old_ff == cmp_ff) begin
          nxt_res[op_sel_ff] = data_ff;
          ev_match           = 1'b1;
        end else begin
          ev_miss = 1'b1;
        end
        ev_done   = 1'b1;
        nxt_state = csw_pkg::csw_idle;
      end
      default: begin
        nxt_state = csw_pkg::csw_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff  <= csw_pkg::csw_idle;
      op_sel_ff <= `CSW_SEL_RESET;
      old_ff    <= `CSW_ZERO32;
      // Resources come up all ones, as on an unmanaged bus
      for (int i = 0; i < NUM_RES; i++) begin
        res_ff[i] <= `CSW_RES_RESET;
      end
    end else begin
      state_ff  <= nxt_state;
      op_sel_ff <= nxt_op_sel;
      old_ff    <= nxt_old;
      for (int i = 0; i < NUM_RES; i++) begin
        res_ff[i] <= nxt_res[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host registers

  logic        busy;
  logic        done_ff;
  logic        nxt_done;
  logic [1:0]  sel_ff;
  logic [1:0]  nxt_sel;
  logic [31:0] nxt_cmp;
  logic [31:0] nxt_data;
  logic [31:0] rom_ff;
  logic [31:0] nxt_rom;
  logic        ev_refused;

  assign busy = (state_ff != csw_pkg::csw_idle);

  always_comb begin
    nxt_done   = done_ff;
    nxt_sel    = sel_ff;
    nxt_cmp    = cmp_ff;
    nxt_data   = data_ff;
    nxt_rom    = rom_ff;
    ev_refused = 1'b0;
    // Operands are frozen while a swap runs to keep it atomic
    if (wr_operand && busy) begin
      ev_refused = 1'b1;
    end else begin
      if (wr_cmp_reg) begin
        nxt_cmp = wr_data;
      end
      if (wr_data_reg) begin
        nxt_data = wr_data;
      end
      if (wr_ctl_reg) begin
        nxt_sel = wr_data[`CSW_SEL_MSB:`CSW_SEL_LSB];
      end
    end
    if (wr_ctl_reg) begin
      nxt_done = 1'b0;
    end
    // Completion wins over a clear in the same cycle
    if (ev_done) begin
      nxt_done = 1'b1;
    end
    if (wr_rom_reg) begin
      nxt_rom[`CSW_INFO_MSB:`CSW_INFO_LSB] =
        wr_data[`CSW_INFO_MSB:`CSW_INFO_LSB];
      nxt_rom[`CSW_SPAN_MSB:`CSW_SPAN_LSB] =
        wr_data[`CSW_SPAN_MSB:`CSW_SPAN_LSB];
      nxt_rom[`CSW_CHK_MSB:`CSW_CHK_LSB] =
        wr_data[`CSW_CHK_MSB:`CSW_CHK_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_ff <= `CSW_DONE_RESET;
      sel_ff  <= `CSW_SEL_RESET;
      cmp_ff  <= `CSW_ZERO32;
      data_ff <= `CSW_ZERO32;
      rom_ff  <= `CSW_ROM_RESET;
    end else begin
      done_ff <= nxt_done;
      sel_ff  <= nxt_sel;
      cmp_ff  <= nxt_cmp;
      data_ff <= nxt_data;
      rom_ff  <= nxt_rom;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt

  logic [`CSW_EV_W-1:0] status_ff;
  logic [`CSW_EV_W-1:0] nxt_status;
  logic [`CSW_EV_W-1:0] enable_ff;
  logic [`CSW_EV_W-1:0] nxt_enable;
  logic [`CSW_EV_W-1:0] events;
  logic                 irq_ff;
  logic                 nxt_irq;

  always_comb begin
    events                  = `CSW_EV_ZERO;
    events[`CSW_EV_DONE]    = ev_done;
    events[`CSW_EV_MATCH]   = ev_match;
    events[`CSW_EV_MISS]    = ev_miss;
    events[`CSW_EV_REFUSED] = ev_refused;
    nxt_enable              = enable_ff;
    nxt_status              = status_ff;
    if (wr_enable_reg) begin
      nxt_enable = wr_data[`CSW_EV_W-1:0];
    end
    if (wr_clear_reg) begin
      nxt_status = nxt_status & ~wr_data[`CSW_EV_W-1:0];
    end
    // New events win over a clear in the same cycle
    nxt_status = nxt_status | events;
    // From next values so the line moves with the status edge
    nxt_irq    = |(nxt_status & nxt_enable);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_ff <= `CSW_EV_ZERO;
      enable_ff <= `CSW_EV_ZERO;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
      irq_ff    <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and external images

  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;
  logic [31:0] rom_out_ff;
  logic [31:0] bus_id_ff;
  logic        busy_ff;
  logic [31:0] ctl_view;
  logic [31:0] nxt_rom_out;
  logic [31:0] nxt_bus_id;
  logic        nxt_busy;

  always_comb begin
    ctl_view                            = `CSW_ZERO32;
    ctl_view[`CSW_DONE_BIT]             = done_ff;
    ctl_view[`CSW_SEL_MSB:`CSW_SEL_LSB] = sel_ff;
    // Images follow their registers on the same edge
    nxt_rom_out                         = nxt_rom;
    nxt_bus_id                          = `CSW_BUS_ID;
    nxt_busy                            = (nxt_state != csw_pkg::csw_idle);
    // Unmapped and write-only offsets read as zero
    nxt_rd_data                         = `CSW_ZERO32;
    if (rd_en) begin
      if (hit(addr, `CSW_OFF_DATA)) begin
        nxt_rd_data = data_ff;
      end else if (hit(addr, `CSW_OFF_CMP)) begin
        nxt_rd_data = cmp_ff;
      end else if (hit(addr, `CSW_OFF_CTL)) begin
        nxt_rd_data = ctl_view;
      end else if (hit(addr, `CSW_OFF_ROM)) begin
        nxt_rd_data = rom_ff;
      end else if (hit(addr, `CSW_OFF_BUSID)) begin
        nxt_rd_data = `CSW_BUS_ID;
      end else if (hit(addr, `CSW_OFF_STATUS)) begin
        nxt_rd_data[`CSW_EV_W-1:0] = status_ff;
      end else if (hit(addr, `CSW_OFF_ENABLE)) begin
        nxt_rd_data[`CSW_EV_W-1:0] = enable_ff;
      end else if (hit(addr, `CSW_OFF_OLD)) begin
        nxt_rd_data = old_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_ff <= `CSW_ZERO32;
      rom_out_ff <= `CSW_ROM_RESET;
      bus_id_ff  <= `CSW_BUS_ID;
      busy_ff    <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rom_out_ff <= nxt_rom_out;
      bus_id_ff  <= nxt_bus_id;
      busy_ff    <= nxt_busy;
    end
  end

  assign rd_data    = rd_data_ff;
  assign irq        = irq_ff;
  assign rom_header = rom_out_ff;
  assign bus_ident  = bus_id_ff;
  assign swap_busy  = busy_ff;

endmodule

`default_nettype wire

// >>> sim/csw_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csw_regs_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic [ADDR_W-1:0] addr,       // Byte address
  input wire logic              clock,      // Clock
  input wire logic              rst_n,      // Sync reset
  input wire logic [31:0]       wr_data,    // Write data
  input wire logic              wr_en,      // Write strobe
  input wire logic              rd_en,      // Read strobe
  input wire logic [31:0]       rd_data,    // Read data
  input wire logic              irq,        // Interrupt
  input wire logic [31:0]       rom_header, // Header image
  input wire logic [31:0]       bus_ident,  // Ident image
  input wire logic              swap_busy   // Engine busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_ID_PORT: assert property (bus_ident == 32'h3133_3934)
    else $error("ident port wrong");
  AST_ID_READ: assert property (rd_en && addr == 8'h1c |=> rd_data == 32'h3133_3934)
    else $error("ident read wrong");
  AST_RSVD_ZERO: assert property (rd_en && addr == 8'h14 |=> rd_data[30:2] == 29'h0)
    else $error("control reserved bits set");
  AST_ROM_PORT: assert property (wr_en && addr == 8'h18
    |=> rom_header == $past(wr_data))
    else $error("header port not updated");
  AST_ROM_READ: assert property (rd_en && addr == 8'h18
    |=> rd_data == $past(rom_header))
    else $error("header read wrong");
  AST_SWAP_WALK: assert property (wr_en && addr == 8'h14 && !swap_busy
    |=> swap_busy [*2] ##1 !swap_busy)
    else $error("swap length wrong");
  AST_DONE_CLEAR: assert property (wr_en && addr == 8'h14 && !swap_busy
    ##2 rd_en && addr == 8'h14 |=> !rd_data[31])
    else $error("done not cleared");
  AST_DONE_SET: assert property ($fell(swap_busy) && !wr_en
    ##1 rd_en && addr == 8'h14 |=> rd_data[31])
    else $error("done not set");
  AST_CMP_READ: assert property (wr_en && addr == 8'h10 && !swap_busy ##1 !wr_en
    ##1 rd_en && addr == 8'h10 |=> rd_data == $past(wr_data, 3))
    else $error("compare read wrong");
endmodule

bind csw_regs csw_regs_checker #(.ADDR_W(ADDR_W)) u_csw_regs_checker (
  .addr(addr), .clock(clock), .rst_n(rst_n), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .rom_header(rom_header),
  .bus_ident(bus_ident), .swap_busy(swap_busy));
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rd_data, rom_header, bus_ident, d;
  logic        irq, swap_busy;
  int          num_errors = 0;
  int          comparisons = 0;

  always #12.5 clock = ~clock;

  csw_regs u_csw_regs (.addr(addr), .clock(clock), .rst_n(rst_n), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .rom_header(rom_header),
    .bus_ident(bus_ident), .swap_busy(swap_busy));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // Bounded wait for the engine to go idle
  task automatic wait_idle;
    int n;
    n = 0;
    while (swap_busy !== 1'b0) begin
      if (n++ > 20) begin
        num_errors++;
        conclude();
      end
      @(posedge clock);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h14);
    check("ctl reset", d, 32'h8000_0000);
    rd(8'h18);
    check("hdr reset", d[31:16], 16'h0);
    check("hdr port reset", rom_header[31:16], 16'h0);
    check("irq reset", irq, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(8'h10, 32'hcafe_f00d);
    rd(8'h10);
    check("compare", d, 32'hcafe_f00d);
    wr(8'h0c, 32'h1357_9bdf);
    rd(8'h0c);
    check("data", d, 32'h1357_9bdf);
    wr(8'h18, 32'ha5c3_1234);
    check("hdr port", rom_header, 32'ha5c3_1234);
    rd(8'h18);
    check("hdr", d, 32'ha5c3_1234);
    wr(8'h1c, 32'h0);
    rd(8'h1c);
    check("ident", d, 32'h3133_3934);
    rd(8'h40);
    check("unmapped", d, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_swap;
    for (int s = 0; s < 4; s++) begin
      wr(8'h38, 32'hf);
      wr(8'h10, 32'hffff_ffff);
      wr(8'h0c, 32'h1234_5670 + s);
      wr(8'h14, 32'hffff_fffc | s);
      wait_idle();
      rd(8'h14);
      check("ctl done", d, 32'h8000_0000 | s);
      rd(8'h3c);
      check("old first", d, 32'hffff_ffff);
      wr(8'h14, s);
      rd(8'h14);
      check("ctl busy", d, s);
      wait_idle();
      rd(8'h3c);
      check("old second", d, 32'h1234_5670 + s);
      rd(8'h30);
      check("status", d, 32'h7);
    end
    $display("test swap done");
  endtask

  task automatic t_irq;
    wr(8'h38, 32'hf);
    wr(8'h34, 32'h1);
    check("irq idle", irq, 1'b0);
    wr(8'h14, 32'h0);
    wait_idle();
    check("irq done", irq, 1'b1);
    wr(8'h34, 32'h0);
    @(posedge clock);
    #1;
    check("irq masked", irq, 1'b0);
    wr(8'h34, 32'h1);
    @(posedge clock);
    #1;
    check("irq unmasked", irq, 1'b1);
    wr(8'h38, 32'h1);
    @(posedge clock);
    #1;
    check("irq cleared", irq, 1'b0);
    $display("test irq done");
  endtask

  // Operand write while the engine runs must be refused
  task automatic t_refused;
    wr(8'h38, 32'hf);
    wr(8'h10, 32'h0000_0001);
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h0bad_0bad);
    wait_idle();
    rd(8'h10);
    check("cmp frozen", d, 32'h0000_0001);
    rd(8'h30);
    check("refused status", d, 32'hd);
    $display("test refused done");
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_swap();
    t_irq();
    t_refused();
    conclude();
  end
endmodule
`default_nettype wire
